// ==== src/mtcp_pkg.sv ====
// shared constants and types of the memory type cache policy block
// assumes a byte address whose low bits select a 64-byte line and 8-byte chunks
`default_nettype none

package mtcp_pkg;

  // ********************************
  // memory types and bus commands
  // ********************************
  // resolved memory type codes
  typedef enum logic [2:0] {
    strong_uncached_type    = 3'h0,
    combining_buffered_type = 3'h1,
    write_through_type      = 3'h4,
    write_protected_type    = 3'h5,
    write_back_type         = 3'h6,
    weak_uncached_type      = 3'h7
  } mtcp_type_e;

  // commands presented on the system bus
  typedef enum logic [2:0] {
    bus_idle      = 3'h0,
    bus_read      = 3'h1,
    bus_write     = 3'h2,
    bus_fill      = 3'h3,
    bus_wback     = 3'h4,
    bus_write_inv = 3'h5,
    bus_combine   = 3'h6
  } mtcp_cmd_e;

  // ********************************
  // address fields
  // ********************************
  localparam int LINE_OFF_W = 6;  // 64-byte line
  localparam int CHUNK_LSB  = 3;  // 8-byte chunk inside a line
  localparam int CHUNK_W    = 3;  // eight chunks per line
  localparam int CHUNKS     = 8;

  // reset values
  localparam logic [CHUNKS-1:0] CB_MASK_RST = 8'h00;

endpackage

`default_nettype wire

// ==== src/mtcp_type_if.sv ====
// carries the page and range memory types to the resolver and the result back
// assumes the policy module drives both inputs from one access request
`default_nettype none

interface mtcp_type_if;
  import mtcp_pkg::*;
  mtcp_type_e page_type;
  mtcp_type_e range_type;
  mtcp_type_e eff_type;

  modport resolver (input page_type, input range_type, output eff_type);
  modport policy   (output page_type, output range_type, input eff_type);
endinterface

`default_nettype wire

// ==== src/mtcp_resolve.sv ====
// combines the page-level and range memory types into one resolved type
// assumes purely combinational use inside the policy block
`default_nettype none

module mtcp_resolve
  import mtcp_pkg::*;
(
  mtcp_type_if.resolver tif
);

  // ********************************
  // resolution
  // ********************************
  // weak uncached comes only from the page table; a range register cannot select it
  always_comb begin
    case (tif.page_type)
      weak_uncached_type: begin
        if (tif.range_type == combining_buffered_type) begin
          tif.eff_type = combining_buffered_type;
        end else begin
          tif.eff_type = weak_uncached_type;
        end
      end
      combining_buffered_type, write_through_type, write_protected_type, write_back_type: begin
        // range weak uncached and unused range codes all fall back to strong uncached
        if (!(tif.range_type inside {combining_buffered_type, write_through_type, write_protected_type,
                                      write_back_type})) begin
          tif.eff_type = strong_uncached_type;
        end else if (tif.page_type == write_back_type) begin
          tif.eff_type = tif.range_type;
        end else begin
          tif.eff_type = tif.page_type;
        end
      end
      default: begin
        tif.eff_type = strong_uncached_type;  // unknown codes fail safe
      end
    endcase
  end

endmodule

`default_nettype wire

// ==== src/mtcp_policy.sv ====
// per-access cache policy for six memory types, with tag store and combining buffer
// assumes one request at a time from the core and a bus that answers with bus_ready
`default_nettype none

module mtcp_policy
  import mtcp_pkg::*;
#(
  parameter int ADDR_W = 32,
  parameter int IDX_W  = 4
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic              req_write,
  input  wire logic              req_spec,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [2:0]        req_page_type,
  input  wire logic [2:0]        req_range_type,
  output logic                   rsp_valid,
  output logic                   rsp_hit,
  output logic                   rsp_refused,
  output logic                   bus_valid,
  input  wire logic              bus_ready,
  output logic [2:0]             bus_cmd,
  output logic [ADDR_W-1:0]      bus_addr,
  output logic [CHUNKS-1:0]      bus_mask,
  input  wire logic              snoop_valid,
  output logic                   snoop_ready,
  input  wire logic [ADDR_W-1:0] snoop_addr,
  input  wire logic              ser_evt
);

  localparam int LINES = 1 << IDX_W;
  localparam int TAG_W = ADDR_W - LINE_OFF_W - IDX_W;

  // ********************************
  // state
  // ********************************
  typedef enum logic [2:0] {
    s_idle     = 3'h0,
    s_dispatch = 3'h1,
    s_flush    = 3'h2,
    s_evict    = 3'h3,
    s_fill     = 3'h4,
    s_single   = 3'h5,
    s_snoop    = 3'h6
  } mtcp_st_e;

  typedef struct packed {
    mtcp_st_e                    st;
    logic                        req_ready;
    logic                        snoop_ready;
    logic                        rsp_valid;
    logic                        rsp_hit;
    logic                        rsp_refused;
    logic                        bus_valid;
    mtcp_cmd_e                   bus_cmd;
    logic [ADDR_W-1:0]           bus_addr;
    logic [CHUNKS-1:0]           bus_mask;
    logic                        op_write;
    logic                        op_spec;
    mtcp_type_e                  op_type;
    logic [ADDR_W-1:0]           op_addr;
    logic                        op_pend;
    logic                        cb_valid;
    logic [ADDR_W-LINE_OFF_W-1:0] cb_line;
    logic [CHUNKS-1:0]           cb_mask;
    logic                        ser_pend;
    logic [LINES-1:0]            valid;
    logic [LINES-1:0]            dirty;
    logic [LINES-1:0][TAG_W-1:0] tag;
  } mtcp_state_s;

  mtcp_state_s r, n;

  // ********************************
  // type resolution
  // ********************************
  mtcp_type_if tif ();
  assign tif.page_type  = mtcp_type_e'(req_page_type);
  assign tif.range_type = mtcp_type_e'(req_range_type);

  mtcp_resolve u_resolve (
    .tif (tif.resolver)
  );

  // ********************************
  // lookup of the held request
  // ********************************
  logic [IDX_W-1:0]  op_idx;
  logic [TAG_W-1:0]  op_tag;
  logic              op_hit;
  logic              victim_dirty;
  logic              op_unc;
  logic              op_cached;
  logic              cb_same;
  logic              flush_need;
  logic [IDX_W-1:0]  sn_idx;
  logic              sn_hit;

  assign op_idx       = r.op_addr[LINE_OFF_W +: IDX_W];
  assign op_tag       = r.op_addr[ADDR_W-1 -: TAG_W];
  assign op_hit       = r.valid[op_idx] && (r.tag[op_idx] == op_tag);
  assign victim_dirty = r.valid[op_idx] && r.dirty[op_idx] && !op_hit;
  assign op_unc       = (r.op_type == strong_uncached_type) || (r.op_type == weak_uncached_type);
  assign op_cached    = (r.op_type == write_through_type) || (r.op_type == write_back_type)
                     || (r.op_type == write_protected_type);
  assign cb_same      = r.cb_line == r.op_addr[ADDR_W-1:LINE_OFF_W];
  // an uncached access is itself a serializing event for the buffer
  assign flush_need   = r.cb_valid && (r.ser_pend || op_unc
                     || (r.op_type == combining_buffered_type && r.op_write && !cb_same));
  assign sn_idx       = snoop_addr[LINE_OFF_W +: IDX_W];
  assign sn_hit       = r.valid[sn_idx] && (r.tag[sn_idx] == snoop_addr[ADDR_W-1 -: TAG_W]);

  // ********************************
  // next state
  // ********************************
  // one access in flight at a time keeps uncached traffic in program order
  always_comb begin
    n             = r;
    n.rsp_valid   = 1'b0;
    n.rsp_hit     = 1'b0;
    n.rsp_refused = 1'b0;
    n.ser_pend    = r.ser_pend || ser_evt;
    case (r.st)
      s_idle: begin
        if (snoop_valid && r.snoop_ready) begin
          n.st = s_idle;
          if (sn_hit) begin
            n.valid[sn_idx] = 1'b0;
            if (r.dirty[sn_idx]) begin
              n.dirty[sn_idx] = 1'b0;
              n.bus_valid     = 1'b1;
              n.bus_cmd       = bus_wback;
              n.bus_addr      = {snoop_addr[ADDR_W-1:LINE_OFF_W], {LINE_OFF_W{1'b0}}};
              n.bus_mask      = {CHUNKS{1'b1}};
              n.st            = s_snoop;
            end
          end
        end else if (req_valid && r.req_ready) begin
          n.op_write = req_write;
          n.op_spec  = req_spec;
          n.op_type  = tif.eff_type;
          n.op_addr  = req_addr;
          n.st       = s_dispatch;
        end else if (r.ser_pend && r.cb_valid) begin
          n.op_pend  = 1'b0;
          n.st       = s_flush;
        end else if (!r.cb_valid) begin
          n.ser_pend = ser_evt;  // nothing to drain, but a new event still counts
        end
        if (n.st == s_flush) begin
          n.bus_valid = 1'b1;
          n.bus_cmd   = bus_combine;
          n.bus_addr  = {r.cb_line, {LINE_OFF_W{1'b0}}};
          n.bus_mask  = r.cb_mask;
          n.ser_pend  = ser_evt;
        end
      end
      s_dispatch: begin
        if (op_unc && r.op_spec) begin
          n.rsp_valid   = 1'b1;
          n.rsp_refused = 1'b1;
          n.st          = s_idle;
        end else if (flush_need) begin
          n.op_pend   = 1'b1;
          n.bus_valid = 1'b1;
          n.bus_cmd   = bus_combine;
          n.bus_addr  = {r.cb_line, {LINE_OFF_W{1'b0}}};
          n.bus_mask  = r.cb_mask;
          n.ser_pend  = ser_evt;
          n.st        = s_flush;
        end else if (op_unc) begin
          n.bus_valid = 1'b1;
          n.bus_cmd   = r.op_write ? bus_write : bus_read;
          n.bus_addr  = r.op_addr;
          n.bus_mask  = CB_MASK_RST;
          n.st        = s_single;
        end else if (r.op_type == combining_buffered_type) begin
          if (r.op_write) begin
            n.cb_valid = 1'b1;
            n.cb_line  = r.op_addr[ADDR_W-1:LINE_OFF_W];
            n.cb_mask[r.op_addr[CHUNK_LSB +: CHUNK_W]] = 1'b1;
            n.ser_pend = ser_evt;
            n.rsp_valid = 1'b1;
            n.st        = s_idle;
          end else begin
            n.bus_valid = 1'b1;
            n.bus_cmd   = bus_read;
            n.bus_addr  = r.op_addr;
            n.bus_mask  = CB_MASK_RST;
            n.st        = s_single;
          end
        end else if (!r.op_write && op_hit) begin
          n.rsp_valid = 1'b1;
          n.rsp_hit   = 1'b1;
          n.st        = s_idle;
        end else if (r.op_write && r.op_type == write_protected_type) begin
          if (op_hit) begin
            n.valid[op_idx] = 1'b0;
          end
          n.bus_valid = 1'b1;
          n.bus_cmd   = bus_write_inv;
          n.bus_addr  = r.op_addr;
          n.bus_mask  = CB_MASK_RST;
          n.st        = s_single;
        end else if (r.op_write && r.op_type == write_through_type) begin
          // a hit line is updated in place; a miss goes to memory without a fill; stores go out singly
          n.bus_valid = 1'b1;
          n.bus_cmd   = bus_write;
          n.bus_addr  = r.op_addr;
          n.bus_mask  = CB_MASK_RST;
          n.st        = s_single;
        end else if (r.op_write && op_hit) begin
          n.dirty[op_idx] = 1'b1;
          n.rsp_valid     = 1'b1;
          n.rsp_hit       = 1'b1;
          n.st            = s_idle;
        end else if (victim_dirty) begin
          n.bus_valid = 1'b1;
          n.bus_cmd   = bus_wback;
          n.bus_addr  = {r.tag[op_idx], op_idx, {LINE_OFF_W{1'b0}}};
          n.bus_mask  = {CHUNKS{1'b1}};
          n.st        = s_evict;
        end else begin
          n.bus_valid = 1'b1;
          n.bus_cmd   = bus_fill;
          n.bus_addr  = {r.op_addr[ADDR_W-1:LINE_OFF_W], {LINE_OFF_W{1'b0}}};
          n.bus_mask  = {CHUNKS{1'b1}};
          n.st        = s_fill;
        end
      end
      s_flush: begin
        if (bus_ready) begin
          n.bus_valid = 1'b0;
          n.bus_cmd   = bus_idle;
          n.cb_valid  = 1'b0;
          n.cb_mask   = CB_MASK_RST;
          n.st        = r.op_pend ? s_dispatch : s_idle;
          n.op_pend   = 1'b0;
        end
      end
      s_evict: begin
        if (bus_ready) begin
          n.dirty[op_idx] = 1'b0;
          n.valid[op_idx] = 1'b0;
          n.bus_cmd       = bus_fill;
          n.bus_addr      = {r.op_addr[ADDR_W-1:LINE_OFF_W], {LINE_OFF_W{1'b0}}};
          n.st            = s_fill;
        end
      end
      s_fill: begin
        if (bus_ready) begin
          n.bus_valid     = 1'b0;
          n.bus_cmd       = bus_idle;
          n.valid[op_idx] = 1'b1;
          n.tag[op_idx]   = op_tag;
          n.dirty[op_idx] = r.op_write;
          n.rsp_valid     = 1'b1;
          n.st            = s_idle;
        end
      end
      s_single, s_snoop: begin
        if (bus_ready) begin
          n.bus_valid = 1'b0;
          n.bus_cmd   = bus_idle;
          n.rsp_valid = (r.st == s_single);
          n.st        = s_idle;
        end
      end
      default: begin
        n.st = s_idle;
      end
    endcase
    n.req_ready   = (n.st == s_idle);
    n.snoop_ready = (n.st == s_idle);
  end

  // registers, cleared as a whole so the tag store starts empty
  always_ff @(posedge clk) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // ********************************
  // outputs
  // ********************************
  assign req_ready   = r.req_ready;
  assign snoop_ready = r.snoop_ready;
  assign rsp_valid   = r.rsp_valid;
  assign rsp_hit     = r.rsp_hit;
  assign rsp_refused = r.rsp_refused;
  assign bus_valid   = r.bus_valid;
  assign bus_cmd     = r.bus_cmd;
  assign bus_addr    = r.bus_addr;
  assign bus_mask    = r.bus_mask;

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_disp_unc;
    r.st == s_dispatch && op_unc && !r.op_spec;
  endsequence

  sequence s_read_miss;
    r.st == s_dispatch && op_cached && !r.op_write && !op_hit && !victim_dirty && !flush_need;
  endsequence

  a_no_alloc_uncached: assert property (bus_valid && bus_cmd == bus_fill |-> op_cached)
    else $error("line fill issued for a non-cacheable type");
  a_no_spec_uncached: assert property (bus_valid && r.st == s_single && op_unc |-> !r.op_spec)
    else $error("speculative access reached the bus for an uncached type");
  a_weak_override: assert property (tif.page_type == weak_uncached_type
      && tif.range_type == combining_buffered_type |-> tif.eff_type == combining_buffered_type)
    else $error("range combining did not override weak uncached");
  a_range_no_weak: assert property (tif.page_type != weak_uncached_type |->
      tif.eff_type != weak_uncached_type)
    else $error("weak uncached resolved without page selection");
  a_unc_drain_first: assert property (s_disp_unc and r.cb_valid |=> bus_cmd == bus_combine
      ##[1:1000] r.st == s_dispatch ##1 bus_cmd != bus_combine)
    else $error("uncached access passed a loaded combining buffer");
  a_read_miss_fill: assert property (s_read_miss |=> bus_valid && bus_cmd == bus_fill
      && bus_addr[LINE_OFF_W-1:0] == '0)
    else $error("cached read miss did not start an aligned line fill");
  a_wt_no_fill: assert property (bus_valid && bus_cmd == bus_fill |-> !r.op_write
      || r.op_type == write_back_type)
    else $error("store filled a line outside write-back");
  a_wb_hit_quiet: assert property (r.st == s_dispatch && r.op_type == write_back_type && r.op_write
      && op_hit && !flush_need |=> rsp_valid && rsp_hit && !bus_valid && r.dirty[op_idx])
    else $error("write-back hit did not stay in cache as modified");
  a_wp_store_inv: assert property (r.st == s_dispatch && r.op_type == write_protected_type
      && r.op_write && !flush_need |=> bus_valid && bus_cmd == bus_write_inv && !op_hit)
    else $error("write-protected store touched the local line");
  a_snoop_wback: assert property (snoop_valid && snoop_ready && sn_hit && r.dirty[sn_idx]
      |=> bus_valid && bus_cmd == bus_wback [*1] ##0 !snoop_ready)
    else $error("snoop on a modified line gave no write-back");

endmodule

`default_nettype wire

// ==== sim/mtcp_bus_model.sv ====
// system bus partner: memory controller answering commands of the policy block
// assumes one command outstanding and the handshake of bus_valid and bus_ready on clk
`default_nettype none

module mtcp_bus_model
  import mtcp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        bus_valid,
  input  wire logic [2:0]  bus_cmd,
  input  wire logic [31:0] bus_addr,
  input  wire logic [7:0]  bus_mask,
  input  wire logic [3:0]  delay,
  output var  logic        bus_ready,
  output var  int          cnt,
  output var  logic        err
);
  timeunit 1ns;
  timeprecision 1ns;

  // ********************************
  // command log and acceptance
  // ********************************
  logic [2:0]  log_cmd  [64];
  logic [31:0] log_addr [64];
  logic [7:0]  log_mask [64];
  int          wait_c;
  logic        pend;
  logic [2:0]  h_cmd;
  logic [31:0] h_addr;
  logic [7:0]  h_mask;

  // ready only after a chosen wait, so a slow memory is seen as often as a quick one
  always @(posedge clk) begin
    if (reset) begin
      bus_ready <= 1'b0;
      wait_c    <= 0;
      cnt       <= 0;
      err       <= 1'b0;
      pend      <= 1'b0;
    end else if (bus_valid && bus_ready) begin
      log_cmd[cnt[5:0]]  <= bus_cmd;
      log_addr[cnt[5:0]] <= bus_addr;
      log_mask[cnt[5:0]] <= bus_mask;
      cnt       <= cnt + 1;
      bus_ready <= 1'b0;
      wait_c    <= 0;
      pend      <= 1'b0;
    end else begin
      // a command withdrawn or changed before acceptance is a protocol fault
      if (pend && !(bus_valid && bus_cmd == h_cmd && bus_addr == h_addr && bus_mask == h_mask))
        err <= 1'b1;
      pend   <= bus_valid;
      h_cmd  <= bus_cmd;
      h_addr <= bus_addr;
      h_mask <= bus_mask;
      if (bus_valid && wait_c >= int'(delay)) bus_ready <= 1'b1;
      else if (bus_valid) wait_c <= wait_c + 1;
    end
  end
endmodule

`default_nettype wire

// ==== sim/mtcp_policy_tb.sv ====
// self-checking bench of the memory type cache policy block
// assumes the bus model partner and a 10 MHz clock with synchronous reset
`default_nettype none

module mtcp_policy_tb
  import mtcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ********************************
  // short aliases of package codes
  // ********************************
  localparam logic [2:0] T_SU = strong_uncached_type;
  localparam logic [2:0] T_CB = combining_buffered_type;
  localparam logic [2:0] T_TH = write_through_type;
  localparam logic [2:0] T_WP = write_protected_type;
  localparam logic [2:0] T_BK = write_back_type;
  localparam logic [2:0] T_WK = weak_uncached_type;
  localparam logic [2:0] C_ID = bus_idle;
  localparam logic [2:0] C_RD = bus_read;
  localparam logic [2:0] C_WR = bus_write;
  localparam logic [2:0] C_FL = bus_fill;
  localparam logic [2:0] C_EV = bus_wback;
  localparam logic [2:0] C_WI = bus_write_inv;
  localparam logic [2:0] C_CB = bus_combine;

  typedef struct {
    logic wr; logic sp; logic [31:0] a; logic [2:0] pt; logic [2:0] rt;
    logic hc; logic h; logic rf; int n; logic [2:0] c; logic [31:0] ca; logic [7:0] m;
  } mtcp_row_s;

  logic        clk, reset, req_valid, req_ready, req_write, req_spec;
  logic [31:0] req_addr, bus_addr, snoop_addr;
  logic [2:0]  req_page_type, req_range_type, bus_cmd;
  logic        rsp_valid, rsp_hit, rsp_refused, bus_valid, bus_ready;
  logic [7:0]  bus_mask;
  logic        snoop_valid, snoop_ready, ser_evt, merr;
  logic [3:0]  bus_delay;
  int          cnt, errors, compares, cyc, b, k;

  mtcp_policy mtcp_policy_inst (.clk(clk), .reset(reset), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_spec(req_spec), .req_addr(req_addr), .req_page_type(req_page_type),
    .req_range_type(req_range_type), .rsp_valid(rsp_valid), .rsp_hit(rsp_hit), .rsp_refused(rsp_refused),
    .bus_valid(bus_valid), .bus_ready(bus_ready), .bus_cmd(bus_cmd), .bus_addr(bus_addr),
    .bus_mask(bus_mask), .snoop_valid(snoop_valid), .snoop_ready(snoop_ready), .snoop_addr(snoop_addr),
    .ser_evt(ser_evt));

  mtcp_bus_model mtcp_bus_model_inst (.clk(clk), .reset(reset), .bus_valid(bus_valid), .bus_cmd(bus_cmd),
    .bus_addr(bus_addr), .bus_mask(bus_mask), .delay(bus_delay), .bus_ready(bus_ready), .cnt(cnt),
    .err(merr));

  // ********************************
  // ordinary cases, run in order since cache state carries over
  // ********************************
  mtcp_row_s rows [24] = '{
    '{0, 0, 32'h0104, T_SU, T_BK, 1, 0, 0, 1, C_RD, 32'h0104, 8'h00},
    '{1, 0, 32'h0108, T_SU, T_BK, 1, 0, 0, 1, C_WR, 32'h0108, 8'h00},
    '{0, 1, 32'h0110, T_SU, T_BK, 1, 0, 1, 0, C_ID, 32'h0, 8'h00},
    '{0, 1, 32'h0118, T_WK, T_BK, 1, 0, 1, 0, C_ID, 32'h0, 8'h00},
    '{0, 1, 32'h0120, T_WK, T_CB, 1, 0, 0, 1, C_RD, 32'h0120, 8'h00},
    '{0, 1, 32'h0128, T_BK, T_WK, 1, 0, 1, 0, C_ID, 32'h0, 8'h00},
    '{0, 1, 32'h0130, T_BK, 3'h2, 1, 0, 1, 0, C_ID, 32'h0, 8'h00},
    '{1, 0, 32'h1008, T_CB, T_BK, 0, 0, 0, 0, C_ID, 32'h0, 8'h00},
    '{1, 0, 32'h1010, T_CB, T_BK, 0, 0, 0, 0, C_ID, 32'h0, 8'h00},
    '{0, 0, 32'h2000, T_SU, T_BK, 1, 0, 0, 2, C_CB, 32'h1000, 8'h06},
    '{0, 0, 32'h3048, T_BK, T_BK, 1, 0, 0, 1, C_FL, 32'h3040, 8'hff},
    '{0, 0, 32'h3048, T_BK, T_BK, 1, 1, 0, 0, C_ID, 32'h0, 8'h00},
    '{1, 0, 32'h3050, T_BK, T_BK, 1, 1, 0, 0, C_ID, 32'h0, 8'h00},
    '{0, 0, 32'h5040, T_BK, T_BK, 1, 0, 0, 2, C_EV, 32'h3040, 8'hff},
    '{1, 0, 32'h6080, T_BK, T_BK, 0, 0, 0, 1, C_FL, 32'h6080, 8'hff},
    '{1, 0, 32'h6088, T_BK, T_BK, 1, 1, 0, 0, C_ID, 32'h0, 8'h00},
    '{0, 0, 32'h7100, T_TH, T_BK, 1, 0, 0, 1, C_FL, 32'h7100, 8'hff},
    '{1, 0, 32'h7108, T_TH, T_BK, 1, 0, 0, 1, C_WR, 32'h7108, 8'h00},
    '{1, 0, 32'h7200, T_TH, T_BK, 1, 0, 0, 1, C_WR, 32'h7200, 8'h00},
    '{0, 0, 32'h7200, T_TH, T_BK, 1, 0, 0, 1, C_FL, 32'h7200, 8'hff},
    '{0, 0, 32'h8300, T_BK, T_WP, 1, 0, 0, 1, C_FL, 32'h8300, 8'hff},
    '{1, 0, 32'h8308, T_BK, T_WP, 0, 0, 0, 1, C_WI, 32'h8308, 8'h00},
    '{0, 1, 32'h8340, T_BK, T_WP, 1, 0, 0, 1, C_FL, 32'h8340, 8'hff},
    '{0, 1, 32'h9000, T_CB, T_BK, 1, 0, 0, 1, C_RD, 32'h9000, 8'h00}
  };

  // ********************************
  // compare and access tasks
  // ********************************
  task automatic chk_flag(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // first bus command since mark b, checked against the log of the partner
  task automatic chk_bus(input logic [2:0] c, input logic [31:0] a, input logic [7:0] m);
    chk_val("bus_cmd", 32'(c), 32'(mtcp_bus_model_inst.log_cmd[b[5:0]]));
    chk_val("bus_addr", a, mtcp_bus_model_inst.log_addr[b[5:0]]);
    chk_val("bus_mask", 32'(m), 32'(mtcp_bus_model_inst.log_mask[b[5:0]]));
  endtask

  // request held until taken, then released; response sampled in its one cycle
  task automatic do_row(input mtcp_row_s r);
    logic h;
    logic rf;
    b = cnt;
    req_write      <= r.wr;
    req_spec       <= r.sp;
    req_addr       <= r.a;
    req_page_type  <= r.pt;
    req_range_type <= r.rt;
    req_valid      <= 1'b1;
    k = 0;
    @(posedge clk);
    while (!(req_ready === 1'b1 && snoop_valid === 1'b0) && k < 100) begin
      @(posedge clk);
      k++;
    end
    req_valid <= 1'b0;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (rsp_valid !== 1'b1 && k < 200);
    h  = rsp_hit;
    rf = rsp_refused;
    chk_flag("rsp_valid", 1'b1, rsp_valid);
    if (r.hc) chk_flag("rsp_hit", r.h, h);
    chk_flag("rsp_refused", r.rf, rf);
    chk_val("bus_count", 32'(r.n), 32'(cnt - b));
    if (r.n > 0) chk_bus(r.c, r.ca, r.m);
  endtask

  task automatic print_verdict;
    if (errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ********************************
  // clock, hang guard and main sequence
  // ********************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ceiling well above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      print_verdict();
    end
  end

  initial begin
    {reset, req_valid, req_write, req_spec, snoop_valid, ser_evt} = 6'h20;
    {req_addr, snoop_addr} = 64'h0;
    {req_page_type, req_range_type} = 6'h00;
    bus_delay = 4'h0;
    errors = 0;
    compares = 0;
    repeat (20) @(posedge clk);
    chk_flag("req_ready", 1'b0, req_ready);
    chk_flag("bus_valid", 1'b0, bus_valid);
    chk_flag("rsp_valid", 1'b0, rsp_valid);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    chk_flag("req_ready", 1'b1, req_ready);
    // vary memory latency across rows so the hold of commands is exercised
    foreach (rows[i]) begin
      bus_delay <= 4'(i % 3);
      do_row(rows[i]);
    end
    // range-selected combining store held until a serializing pulse
    do_row('{1, 0, 32'ha018, T_BK, T_CB, 0, 0, 0, 0, C_ID, 32'h0, 8'h00});
    b = cnt;
    ser_evt <= 1'b1;
    @(posedge clk);
    ser_evt <= 1'b0;
    k = 0;
    while (cnt == b && k < 50) begin
      @(posedge clk);
      k++;
    end
    chk_bus(C_CB, 32'ha000, 8'h08);
    // snoop of a modified line forces its write-back
    b = cnt;
    snoop_addr  <= 32'h6080;
    snoop_valid <= 1'b1;
    @(posedge clk);
    while (snoop_ready !== 1'b1 && k < 100) begin
      @(posedge clk);
      k++;
    end
    snoop_valid <= 1'b0;
    @(posedge clk);
    chk_flag("snoop_ready", 1'b0, snoop_ready);
    k = 0;
    while (cnt == b && k < 50) begin
      @(posedge clk);
      k++;
    end
    chk_bus(C_EV, 32'h6080, 8'hff);
    repeat (2) @(posedge clk);
    do_row('{0, 0, 32'h6080, T_BK, T_BK, 1, 0, 0, 1, C_FL, 32'h6080, 8'hff});
    chk_flag("bus_hold", 1'b0, merr);
    print_verdict();
  end
endmodule

`default_nettype wire
